// ==== hdl/ilo_pkg.sv ====
// shared constants and types for the indexed literal offset decoder
package ilo_pkg;
  // ==========================================================
  // widths
  localparam int unsigned BUS_AW  = 4;
  localparam int unsigned BUS_DW  = 16;
  localparam int unsigned MEM_AW  = 12;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned FLAG_W  = 5;
  localparam int unsigned BANK_W  = 4;
  // ==========================================================
  // register map, word per index
  localparam logic [BUS_AW-1:0] REG_CTRL    = 4'h0;
  localparam logic [BUS_AW-1:0] REG_INSTR   = 4'h1;
  localparam logic [BUS_AW-1:0] REG_SFP     = 4'h2;
  localparam logic [BUS_AW-1:0] REG_BANK    = 4'h3;
  localparam logic [BUS_AW-1:0] REG_ACC     = 4'h4;
  localparam logic [BUS_AW-1:0] REG_FLAGS   = 4'h5;
  localparam logic [BUS_AW-1:0] REG_LAST_EA = 4'h6;
  localparam int unsigned CTRL_BUSY_BIT     = 0;
  localparam int unsigned CTRL_FUSE_BIT     = 1;
  localparam int unsigned CTRL_INDEXED_BIT  = 2;
  // ==========================================================
  // addressing
  localparam logic [BYTE_W-1:0] OFFSET_MAX     = 8'h5f;
  localparam logic [MEM_AW-1:0] ACCESS_LO_BASE = 12'h000;
  localparam logic [MEM_AW-1:0] ACCESS_HI_BASE = 12'hf00;
  // ==========================================================
  // opcode fields
  localparam int unsigned A_BIT   = 8;
  localparam int unsigned D_BIT   = 9;
  localparam int unsigned B_LSB   = 9;
  localparam logic [BUS_DW-1:0] ADD_MASK  = 16'hfc00;
  localparam logic [BUS_DW-1:0] ADD_CODE  = 16'h2400;
  localparam logic [BUS_DW-1:0] BSET_MASK = 16'hf000;
  localparam logic [BUS_DW-1:0] BSET_CODE = 16'h8000;
  localparam logic [BUS_DW-1:0] FILL_MASK = 16'hfe00;
  localparam logic [BUS_DW-1:0] FILL_CODE = 16'h6800;
  localparam logic [BYTE_W-1:0] FILL_VALUE = 8'hff;
  // flag positions
  localparam int unsigned FLAG_C  = 0;
  localparam int unsigned FLAG_DC = 1;
  localparam int unsigned FLAG_Z  = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_N  = 4;
  // ==========================================================
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } ilo_phase_type;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ADD  = 2'b01,
    OP_BSET = 2'b10,
    OP_FILL = 2'b11
  } ilo_op_type;
endpackage

// ==== hdl/ilo_addr_gen.sv ====
// effective data address from the file field of a byte or bit opcode
`timescale 1ns/10ps
module ilo_addr_gen (
  input  wire logic                        i_ext_en,
  input  wire logic                        i_access_sel,
  input  wire logic [ilo_pkg::BYTE_W-1:0]  i_file,
  input  wire logic [ilo_pkg::MEM_AW-1:0]  i_frame_ptr,
  input  wire logic [ilo_pkg::BANK_W-1:0]  i_bank,
  output logic      [ilo_pkg::MEM_AW-1:0]  o_eff_addr,
  output logic                             o_indexed
);
  import ilo_pkg::*;

  logic                low_half;
  logic [MEM_AW-1:0]   sum_w;

  // ==========================================================
  // address select
  always_comb begin
    low_half  = (i_file <= OFFSET_MAX);
    // wraps inside the 4 KB data space
    sum_w     = MEM_AW'(i_frame_ptr + {4'h0, i_file});
    o_indexed = i_ext_en && !i_access_sel && low_half;
    if (i_access_sel) begin
      o_eff_addr = {i_bank, i_file};
    end else if (o_indexed) begin
      o_eff_addr = sum_w;
    end else if (low_half) begin
      o_eff_addr = ACCESS_LO_BASE | {4'h0, i_file};
    end else begin
      o_eff_addr = ACCESS_HI_BASE | {4'h0, i_file};
    end
  end
endmodule

// ==== hdl/ilo_offset_decode.sv ====
// operand decode and execute core for indexed literal offset addressing
`timescale 1ns/10ps
// Function
// - extension off: file field is literal, access bank or bank-select bank.
// - extension on, a=0, field up to 5Fh: address is frame pointer plus field.
// - fields above 5Fh with a=0 keep their literal access bank meaning.
// - indexing applies to every byte and bit opcode carrying the a bit.
// - frame pointer zero gives the legacy access RAM addresses.
// - indexed add sums accumulator and operand, updating N, OV, C, DC, Z.
// - destination bit 0 writes the accumulator, 1 writes the memory byte.
// - indexed bit set sets bit b of the operand, flags untouched.
// - indexed fill writes all ones to the operand, flags untouched.
// - one word, one cycle: decode, read, process, write in fourth phase.
// - fuse bit 1 enables extension and indexing, 0 disables both.
// - effective address stays inside the 4096 byte data space.
module ilo_offset_decode (
  input  wire logic                        i_clock,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_clk_en,
  input  wire logic                        i_extension_enable_fuse,
  input  wire logic [ilo_pkg::BUS_AW-1:0]  i_addr,
  input  wire logic [ilo_pkg::BUS_DW-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [ilo_pkg::BUS_DW-1:0]  o_rdata,
  output logic      [ilo_pkg::MEM_AW-1:0]  o_mem_addr,
  output logic                             o_mem_rd,
  output logic                             o_mem_wr,
  output logic      [ilo_pkg::BYTE_W-1:0]  o_mem_wdata,
  input  wire logic [ilo_pkg::BYTE_W-1:0]  i_mem_rdata,
  output logic                             o_busy
);
  import ilo_pkg::*;

  // ==========================================================
  // state
  logic                fuse_meta_q,  fuse_meta_d;
  logic                fuse_q,       fuse_d;
  ilo_phase_type       phase_q,      phase_d;
  ilo_op_type          op_q,         op_d;
  logic [BUS_DW-1:0]   ir_q,         ir_d;
  logic [MEM_AW-1:0]   sfp_q,        sfp_d;
  logic [BANK_W-1:0]   bank_q,       bank_d;
  logic [BYTE_W-1:0]   acc_q,        acc_d;
  logic [FLAG_W-1:0]   flags_q,      flags_d;
  logic [FLAG_W-1:0]   pend_flags_q, pend_flags_d;
  logic                upd_flags_q,  upd_flags_d;
  logic                to_acc_q,     to_acc_d;
  logic [BYTE_W-1:0]   result_q,     result_d;
  logic [MEM_AW-1:0]   ea_q,         ea_d;
  logic                indexed_q,    indexed_d;
  logic [BUS_DW-1:0]   rdata_q,      rdata_d;
  logic [MEM_AW-1:0]   mem_addr_q,   mem_addr_d;
  logic                mem_rd_q,     mem_rd_d;
  logic                mem_wr_q,     mem_wr_d;
  logic [BYTE_W-1:0]   mem_wdata_q,  mem_wdata_d;
  logic                busy_q,       busy_d;

  logic [MEM_AW-1:0]   ea_w;
  logic                indexed_w;
  logic [BYTE_W:0]     sum9;
  logic [4:0]          low_sum;
  logic [BYTE_W-1:0]   sum8;
  logic [BYTE_W-1:0]   bit_mask;
  ilo_op_type          op_dec;

  // ==========================================================
  // address generation, shared by every opcode carrying an a bit
  ilo_addr_gen u_addr_gen (
    .i_ext_en     (fuse_q),
    .i_access_sel (ir_q[A_BIT]),
    .i_file       (ir_q[BYTE_W-1:0]),
    .i_frame_ptr  (sfp_q),
    .i_bank       (bank_q),
    .o_eff_addr   (ea_w),
    .o_indexed    (indexed_w)
  );

  // ==========================================================
  // next state
  always_comb begin
    fuse_meta_d  = i_extension_enable_fuse;
    fuse_d       = fuse_meta_q;
    phase_d      = phase_q;
    op_d         = op_q;
    ir_d         = ir_q;
    sfp_d        = sfp_q;
    bank_d       = bank_q;
    acc_d        = acc_q;
    flags_d      = flags_q;
    pend_flags_d = pend_flags_q;
    upd_flags_d  = upd_flags_q;
    to_acc_d     = to_acc_q;
    result_d     = result_q;
    ea_d         = ea_q;
    indexed_d    = indexed_q;
    mem_addr_d   = mem_addr_q;
    mem_rd_d     = 1'b0;
    mem_wr_d     = 1'b0;
    mem_wdata_d  = mem_wdata_q;
    rdata_d      = '0;

    // opcode classes
    if ((ir_q & ADD_MASK) == ADD_CODE) begin
      op_dec = OP_ADD;
    end else if ((ir_q & BSET_MASK) == BSET_CODE) begin
      op_dec = OP_BSET;
    end else if ((ir_q & FILL_MASK) == FILL_CODE) begin
      op_dec = OP_FILL;
    end else begin
      op_dec = OP_NONE;
    end

    sum9     = {1'b0, acc_q} + {1'b0, i_mem_rdata};
    low_sum  = {1'b0, acc_q[3:0]} + {1'b0, i_mem_rdata[3:0]};
    sum8     = sum9[BYTE_W-1:0];
    bit_mask = BYTE_W'(1) << ir_q[B_LSB +: 3];

    // register writes; core updates below take precedence
    if (i_wr) begin
      case (i_addr)
        REG_INSTR: begin
          if (phase_q == PH_IDLE) begin
            ir_d    = i_wdata;
            phase_d = PH_Q1;
          end
        end
        REG_SFP:   sfp_d   = i_wdata[MEM_AW-1:0];
        REG_BANK:  bank_d  = i_wdata[BANK_W-1:0];
        REG_ACC:   acc_d   = i_wdata[BYTE_W-1:0];
        REG_FLAGS: flags_d = i_wdata[FLAG_W-1:0];
        default: ;
      endcase
    end

    // one instruction cycle in four phases
    case (phase_q)
      // idle keeps any start set by the opcode write above
      PH_IDLE: ;
      PH_Q1: begin
        // decode: latch operand address and class
        op_d       = op_dec;
        ea_d       = ea_w;
        indexed_d  = indexed_w;
        mem_addr_d = ea_w;
        mem_rd_d   = 1'b1;
        phase_d    = PH_Q2;
      end
      PH_Q2: begin
        // memory answers in the following phase
        phase_d = PH_Q3;
      end
      PH_Q3: begin
        upd_flags_d = 1'b0;
        to_acc_d    = 1'b0;
        case (op_q)
          OP_ADD: begin
            result_d              = sum8;
            pend_flags_d[FLAG_C]  = sum9[BYTE_W];
            pend_flags_d[FLAG_DC] = low_sum[4];
            pend_flags_d[FLAG_Z]  = (sum8 == '0);
            pend_flags_d[FLAG_N]  = sum8[BYTE_W-1];
            pend_flags_d[FLAG_OV] = (acc_q[BYTE_W-1] == i_mem_rdata[BYTE_W-1]) &&
                                    (sum8[BYTE_W-1] != acc_q[BYTE_W-1]);
            upd_flags_d           = 1'b1;
            to_acc_d              = !ir_q[D_BIT];
            mem_wr_d              = ir_q[D_BIT];
          end
          OP_BSET: begin
            result_d = i_mem_rdata | bit_mask;
            mem_wr_d = 1'b1;
          end
          OP_FILL: begin
            result_d = FILL_VALUE;
            mem_wr_d = 1'b1;
          end
          default: result_d = result_q;
        endcase
        mem_wdata_d = result_d;
        phase_d     = PH_Q4;
      end
      PH_Q4: begin
        // destination write lands in this phase
        if (to_acc_q) begin
          acc_d = result_q;
        end
        if (upd_flags_q) begin
          flags_d = pend_flags_q;
        end
        phase_d = PH_IDLE;
      end
      default: phase_d = PH_IDLE;
    endcase

    busy_d = (phase_d != PH_IDLE);

    // read port answers one cycle after the strobe
    if (i_rd) begin
      case (i_addr)
        REG_CTRL: begin
          rdata_d[CTRL_BUSY_BIT]    = busy_q;
          rdata_d[CTRL_FUSE_BIT]    = fuse_q;
          rdata_d[CTRL_INDEXED_BIT] = indexed_q;
        end
        REG_INSTR:   rdata_d = ir_q;
        REG_SFP:     rdata_d[MEM_AW-1:0] = sfp_q;
        REG_BANK:    rdata_d[BANK_W-1:0] = bank_q;
        REG_ACC:     rdata_d[BYTE_W-1:0] = acc_q;
        REG_FLAGS:   rdata_d[FLAG_W-1:0] = flags_q;
        REG_LAST_EA: rdata_d[MEM_AW-1:0] = ea_q;
        default:     rdata_d = '0;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fuse_meta_q  <= 1'b0;
      fuse_q       <= 1'b0;
      phase_q      <= PH_IDLE;
      op_q         <= OP_NONE;
      ir_q         <= '0;
      sfp_q        <= '0;
      bank_q       <= '0;
      acc_q        <= '0;
      flags_q      <= '0;
      pend_flags_q <= '0;
      upd_flags_q  <= 1'b0;
      to_acc_q     <= 1'b0;
      result_q     <= '0;
      ea_q         <= '0;
      indexed_q    <= 1'b0;
      rdata_q      <= '0;
      mem_addr_q   <= '0;
      mem_rd_q     <= 1'b0;
      mem_wr_q     <= 1'b0;
      mem_wdata_q  <= '0;
      busy_q       <= 1'b0;
    end else if (i_clk_en) begin
      fuse_meta_q  <= fuse_meta_d;
      fuse_q       <= fuse_d;
      phase_q      <= phase_d;
      op_q         <= op_d;
      ir_q         <= ir_d;
      sfp_q        <= sfp_d;
      bank_q       <= bank_d;
      acc_q        <= acc_d;
      flags_q      <= flags_d;
      pend_flags_q <= pend_flags_d;
      upd_flags_q  <= upd_flags_d;
      to_acc_q     <= to_acc_d;
      result_q     <= result_d;
      ea_q         <= ea_d;
      indexed_q    <= indexed_d;
      rdata_q      <= rdata_d;
      mem_addr_q   <= mem_addr_d;
      mem_rd_q     <= mem_rd_d;
      mem_wr_q     <= mem_wr_d;
      mem_wdata_q  <= mem_wdata_d;
      busy_q       <= busy_d;
    end
  end

  assign o_rdata     = rdata_q;
  assign o_mem_addr  = mem_addr_q;
  assign o_mem_rd    = mem_rd_q;
  assign o_mem_wr    = mem_wr_q;
  assign o_mem_wdata = mem_wdata_q;
  assign o_busy      = busy_q;

  // ==========================================================
  // checks; a frozen clock enable suspends them
  sequence s_decode;
    phase_q == PH_Q1;
  endsequence
  sequence s_read;
    (phase_q == PH_Q2) && mem_rd_q;
  endsequence
  sequence s_process;
    (phase_q == PH_Q3) && !mem_rd_q;
  endsequence
  sequence s_write;
    phase_q == PH_Q4;
  endsequence

  property p_literal_low;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (!fuse_q && !ir_q[A_BIT] && ir_q[BYTE_W-1:0] <= OFFSET_MAX) |-> (ea_w == {4'h0, ir_q[BYTE_W-1:0]});
  endproperty
  a_literal_low: assert property (p_literal_low) else $error("literal access address wrong");

  property p_indexed_sum;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (fuse_q && !ir_q[A_BIT] && ir_q[BYTE_W-1:0] <= OFFSET_MAX)
      |-> indexed_w && (ea_w == MEM_AW'(sfp_q + {4'h0, ir_q[BYTE_W-1:0]}));
  endproperty
  a_indexed_sum: assert property (p_indexed_sum) else $error("indexed address not frame plus offset");

  property p_high_literal;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (!ir_q[A_BIT] && ir_q[BYTE_W-1:0] > OFFSET_MAX) |-> !indexed_w && (ea_w[MEM_AW-1:BYTE_W] == 4'hf);
  endproperty
  a_high_literal: assert property (p_high_literal) else $error("high access field was indexed");

  property p_banked;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    ir_q[A_BIT] |-> !indexed_w && (ea_w == {bank_q, ir_q[BYTE_W-1:0]});
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_zero_frame;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (fuse_q && sfp_q == '0 && !ir_q[A_BIT] && ir_q[BYTE_W-1:0] <= OFFSET_MAX)
      |-> (ea_w == {4'h0, ir_q[BYTE_W-1:0]});
  endproperty
  a_zero_frame: assert property (p_zero_frame) else $error("zero frame differs from legacy map");

  property p_fuse_off;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    !fuse_q |-> !indexed_w;
  endproperty
  a_fuse_off: assert property (p_fuse_off) else $error("indexing while fuse clear");

  property p_four_phases;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (phase_q == PH_IDLE && i_wr && i_addr == REG_INSTR)
      |=> s_decode ##1 s_read ##1 s_process ##1 s_write ##1 (phase_q == PH_IDLE && !busy_q);
  endproperty
  a_four_phases: assert property (p_four_phases) else $error("instruction cycle not four phases");

  property p_add_acc;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (phase_q == PH_Q3 && op_q == OP_ADD && !ir_q[D_BIT])
      |=> !mem_wr_q ##1 (acc_q == $past(result_q)) && (flags_q == $past(pend_flags_q));
  endproperty
  a_add_acc: assert property (p_add_acc) else $error("add to accumulator wrong");

  property p_add_mem;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (phase_q == PH_Q3 && op_q == OP_ADD && ir_q[D_BIT])
      |=> mem_wr_q && (mem_wdata_q == $past(sum8)) && (mem_addr_q == ea_q);
  endproperty
  a_add_mem: assert property (p_add_mem) else $error("add to memory wrong");

  property p_bit_set;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (phase_q == PH_Q3 && op_q == OP_BSET)
      |=> mem_wr_q && (mem_wdata_q == ($past(i_mem_rdata) | $past(bit_mask))) ##1 (flags_q == $past(flags_q, 2));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong or flags moved");

  property p_fill;
    @(posedge i_clock) disable iff (!i_rst_n || !i_clk_en)
    (phase_q == PH_Q3 && op_q == OP_FILL)
      |=> mem_wr_q && (mem_wdata_q == FILL_VALUE) ##1 (flags_q == $past(flags_q, 2));
  endproperty
  a_fill: assert property (p_fill) else $error("fill wrong or flags moved");
endmodule

// ==== dv/test_ilo_offset_decode.sv ====
// self-checking bench for the indexed literal offset decoder
`timescale 1ns/10ps
module test_ilo_offset_decode;
  import ilo_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic        i_clock                 = 1'b0;
  logic        i_rst_n                 = 1'b0;
  logic        i_clk_en                = 1'b1;
  logic        i_extension_enable_fuse = 1'b0;
  logic [3:0]  i_addr                  = 4'h0;
  logic [15:0] i_wdata                 = 16'h0000;
  logic        i_wr                    = 1'b0;
  logic        i_rd                    = 1'b0;
  logic [7:0]  i_mem_rdata             = 8'h00;
  logic [15:0] o_rdata;
  logic [11:0] o_mem_addr;
  logic        o_mem_rd;
  logic        o_mem_wr;
  logic        o_busy;
  logic [7:0]  o_mem_wdata;
  logic [7:0]  mem [0:4095];
  logic [11:0] rd_ea;
  logic [11:0] wr_ea;
  logic [7:0]  wr_val;
  logic [15:0] rv;
  int          rd_cnt;
  int          wr_cnt;
  int          num_errors;
  int          check_count;
  // sfp, low opcode bits {a, field}, expected address, expected indexed flag
  logic [11:0] t_sfp [0:5] = '{12'ha00, 12'ha00, 12'ha00, 12'ha00, 12'h000, 12'hff0};
  logic [8:0]  t_af  [0:5] = '{9'h02c, 9'h05f, 9'h060, 9'h12c, 9'h02c, 9'h020};
  logic [11:0] t_ea  [0:5] = '{12'ha2c, 12'ha5f, 12'hf60, 12'h32c, 12'h02c, 12'h010};
  logic        t_ix  [0:5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  ilo_offset_decode DUT (
    .i_clock                 (i_clock),
    .i_rst_n                 (i_rst_n),
    .i_clk_en                (i_clk_en),
    .i_extension_enable_fuse (i_extension_enable_fuse),
    .i_addr                  (i_addr),
    .i_wdata                 (i_wdata),
    .i_wr                    (i_wr),
    .i_rd                    (i_rd),
    .o_rdata                 (o_rdata),
    .o_mem_addr              (o_mem_addr),
    .o_mem_rd                (o_mem_rd),
    .o_mem_wr                (o_mem_wr),
    .o_mem_wdata             (o_mem_wdata),
    .i_mem_rdata             (i_mem_rdata),
    .o_busy                  (o_busy)
  );

  initial begin
    forever #50 i_clock = ~i_clock;
  end

  // ==========================================================
  // data memory: answers only in the cycle after a read strobe
  always @(posedge i_clock) begin
    // toggling filler so a late sample cannot match by luck
    i_mem_rdata <= o_mem_rd ? mem[o_mem_addr] : ~i_mem_rdata;
    if (o_mem_rd) begin
      rd_cnt <= rd_cnt + 1;
      rd_ea  <= o_mem_addr;
    end
    if (o_mem_wr) begin
      wr_cnt           <= wr_cnt + 1;
      wr_ea            <= o_mem_addr;
      wr_val           <= o_mem_wdata;
      mem[o_mem_addr]  <= o_mem_wdata;
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [4:0] add_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] mask,
                        input logic [15:0] exp);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1 rv = o_rdata;
    chk(name, exp, rv & mask);
  endtask

  // one instruction: phase count, memory strobes and addresses
  task automatic run(input logic [15:0] op, input logic [11:0] ea, input logic wr_exp,
                     input logic [7:0] wd);
    int n;
    rd_cnt = 0;
    wr_cnt = 0;
    n      = 0;
    wr_reg(REG_INSTR, op);
    #1;
    while (o_busy === 1'b1 && n < 20) begin
      @(posedge i_clock);
      #1 n++;
    end
    chk("busy cycles", 16'd4, 16'(n));
    chk("read strobes", 16'd1, 16'(rd_cnt));
    chk("read address", {4'h0, ea}, {4'h0, rd_ea});
    chk("write strobes", {15'h0000, wr_exp}, 16'(wr_cnt));
    if (wr_exp) begin
      chk("write address", {4'h0, ea}, {4'h0, wr_ea});
      chk("write data", {8'h00, wd}, {8'h00, wr_val});
    end
    rd_chk("last address", REG_LAST_EA, 16'hffff, {4'h0, ea});
  endtask

  task automatic add_case(input logic [7:0] acc, input logic [7:0] m, input logic [7:0] f, input logic d);
    logic [7:0] sum;
    sum = acc + m;
    mem[12'ha00 + 12'(f)] = m;
    wr_reg(REG_ACC, {8'h00, acc});
    run(ADD_CODE | {6'h00, d, 1'b0, f}, 12'ha00 + 12'(f), d, sum);
    rd_chk("accumulator", REG_ACC, 16'hffff, {8'h00, d ? acc : sum});
    rd_chk("flags", REG_FLAGS, 16'hffff, {11'h000, add_flags(acc, m)});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    for (int k = 0; k < 4096; k++) begin
      mem[k] = 8'h00;
    end
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      rd_chk("reset value", 4'(r), 16'hffff, 16'h0000);
    end
    wr_reg(4'h7, 16'hffff);
    rd_chk("unmapped", 4'h7, 16'hffff, 16'h0000);
    wr_reg(REG_SFP, 16'hfa00);
    rd_chk("frame pointer", REG_SFP, 16'hffff, 16'h0a00);
    wr_reg(REG_BANK, 16'h0013);
    rd_chk("bank", REG_BANK, 16'hffff, 16'h0003);
    $display("test registers done");

    // extension off: literal access bank and banked forms
    run(FILL_CODE | 16'h002c, 12'h02c, 1'b1, 8'hff);
    rd_chk("indexed flag", REG_CTRL, 16'h0006, 16'h0000);
    run(FILL_CODE | 16'h012c, 12'h32c, 1'b1, 8'hff);
    run(FILL_CODE | 16'h0080, 12'hf80, 1'b1, 8'hff);
    $display("test extension off done");

    @(posedge i_clock);
    i_extension_enable_fuse <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd_chk("fuse seen", REG_CTRL, 16'h0006, 16'h0002);
    wr_reg(REG_SFP, 16'h0a00);
    add_case(8'h17, 8'h20, 8'h2c, 1'b0);
    add_case(8'h37, 8'hc9, 8'h2d, 1'b1);
    add_case(8'h37, 8'h50, 8'h2e, 1'b0);
    $display("test indexed add done");

    // a write while the clock enable is low must not land
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    wr_reg(REG_ACC, 16'h00aa);
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    rd_chk("frozen accumulator", REG_ACC, 16'hffff, 16'h0087);
    $display("test clock enable done");

    for (int b = 0; b < 8; b++) begin
      mem[12'ha0a] = 8'h55;
      run(BSET_CODE | 16'(b << 9) | 16'h000a, 12'ha0a, 1'b1, 8'h55 | 8'(1 << b));
    end
    rd_chk("flags kept", REG_FLAGS, 16'hffff, 16'h0018);
    $display("test indexed bit set done");

    for (int t = 0; t < 6; t++) begin
      wr_reg(REG_SFP, {4'h0, t_sfp[t]});
      run(FILL_CODE | {7'h00, t_af[t]}, t_ea[t], 1'b1, FILL_VALUE);
      rd_chk("indexed flag", REG_CTRL, 16'h0004, {13'h0000, t_ix[t], 2'b00});
    end
    rd_chk("flags kept", REG_FLAGS, 16'hffff, 16'h0018);
    $display("test indexed fill done");
    // unknown opcode: four phases, indexed read, no write
    run(16'h0000, 12'hff0, 1'b0, 8'h00);
    rd_chk("accumulator kept", REG_ACC, 16'hffff, 16'h0087);
    $display("test unknown opcode done");
    end_of_test;
  end

  // about 270 cycles expected; generous ceiling
  initial begin
    repeat (6000) @(posedge i_clock);
    num_errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test;
  end
endmodule
